// *** hw/mrc_reporter.sv ***
// result code reporter: turns call events into numeric codes
// assumes events are one-cycle pulses synchronous to clk and that
// the negotiation details stand beside ev_connect in its cycle

module mrc_reporter #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  input  wire logic              ev_no_answer,
  input  wire logic              quiet_answer_mod,
  input  wire logic              ev_connect,
  input  wire logic              ec_mode,
  input  wire mrc_pkg::mrc_rate_t dte_rate,
  input  wire mrc_pkg::mrc_rate_t line_rate,
  input  wire logic              streaming_used,
  input  wire mrc_pkg::mrc_prot_t protocol,
  input  wire mrc_pkg::mrc_comp_t compression,
  output logic [7:0]             code,
  output logic                   code_valid,
  output logic                   busy,
  output logic                   irq
);

  generate
    if (ADDR_W < 8)
    begin : g_bad_addr
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  typedef enum logic [2:0] {
    S_IDLE, S_CARRIER, S_PROTOCOL, S_STREAM, S_COMPRESS, S_CONNECT
  } mrc_state_t;

  // connect code from the reported rate
  function automatic logic [7:0] connect_code(mrc_pkg::mrc_rate_t r, logic basic);
    logic [7:0] c;
    c = mrc_pkg::C_CONNECT;
    unique case (r)
      mrc_pkg::R_300:     c = mrc_pkg::C_CONNECT;
      mrc_pkg::R_1200:    c = mrc_pkg::C_CON_1200;
      mrc_pkg::R_1200_75: c = mrc_pkg::C_CON_1200_75;
      mrc_pkg::R_75_1200: c = mrc_pkg::C_CON_75_1200;
      mrc_pkg::R_2400:    c = mrc_pkg::C_CON_2400;
      mrc_pkg::R_4800:    c = mrc_pkg::C_CON_4800;
      mrc_pkg::R_9600:    c = mrc_pkg::C_CON_9600;
      mrc_pkg::R_14400:   c = mrc_pkg::C_CON_14400;
      mrc_pkg::R_19200:   c = mrc_pkg::C_CON_19200;
      mrc_pkg::R_7200:    c = mrc_pkg::C_CON_7200;
      mrc_pkg::R_12000:   c = mrc_pkg::C_CON_12000;
      mrc_pkg::R_38400:   c = mrc_pkg::C_CON_38400;
      default:            c = mrc_pkg::C_CONNECT;
    endcase
    if (basic && is_extended(r))
    begin
      c = mrc_pkg::C_CONNECT;
    end
    return c;
  endfunction : connect_code

  // rates whose codes the basic set suppresses
  function automatic logic is_extended(mrc_pkg::mrc_rate_t r);
    return r inside {mrc_pkg::R_2400, mrc_pkg::R_4800, mrc_pkg::R_7200,
                     mrc_pkg::R_9600, mrc_pkg::R_12000, mrc_pkg::R_14400,
                     mrc_pkg::R_19200, mrc_pkg::R_38400};
  endfunction : is_extended

  // carrier code; none for rates with no carrier message
  function automatic logic [7:0] carrier_code(mrc_pkg::mrc_rate_t r);
    logic [7:0] c;
    c = mrc_pkg::C_NONE;
    unique case (r)
      mrc_pkg::R_300:     c = mrc_pkg::C_CAR_300;
      mrc_pkg::R_1200_75: c = mrc_pkg::C_CAR_1200_75;
      mrc_pkg::R_75_1200: c = mrc_pkg::C_CAR_75_1200;
      mrc_pkg::R_1200:    c = mrc_pkg::C_CAR_1200;
      mrc_pkg::R_2400:    c = mrc_pkg::C_CAR_2400;
      mrc_pkg::R_4800:    c = mrc_pkg::C_CAR_4800;
      mrc_pkg::R_7200:    c = mrc_pkg::C_CAR_7200;
      mrc_pkg::R_9600:    c = mrc_pkg::C_CAR_9600;
      mrc_pkg::R_12000:   c = mrc_pkg::C_CAR_12000;
      mrc_pkg::R_14400:   c = mrc_pkg::C_CAR_14400;
      default:            c = mrc_pkg::C_NONE;
    endcase
    return c;
  endfunction : carrier_code

  mrc_state_t          state_r;
  mrc_state_t          state_nxt;
  logic [7:0]          code_r;
  logic [7:0]          code_nxt;
  logic                valid_r;
  logic                valid_nxt;
  mrc_pkg::mrc_rate_t  dte_r;
  mrc_pkg::mrc_rate_t  dte_nxt;
  mrc_pkg::mrc_rate_t  line_r;
  mrc_pkg::mrc_rate_t  line_nxt;
  mrc_pkg::mrc_prot_t  prot_r;
  mrc_pkg::mrc_prot_t  prot_nxt;
  mrc_pkg::mrc_comp_t  comp_r;
  mrc_pkg::mrc_comp_t  comp_nxt;
  logic                ec_r;
  logic                ec_nxt;
  logic                stream_r;
  logic                stream_nxt;
  logic [7:0]          car_c;
  logic                noans_hit;

  assign car_c = carrier_code(line_r);

  logic [mrc_pkg::CTRL_W-1:0] ctrl_r;
  logic [mrc_pkg::CTRL_W-1:0] ctrl_nxt;
  logic [mrc_pkg::ST_W-1:0]   st_r;
  logic [mrc_pkg::ST_W-1:0]   st_nxt;
  logic [mrc_pkg::ST_W-1:0]   en_r;
  logic [mrc_pkg::ST_W-1:0]   en_nxt;
  logic [mrc_pkg::ST_W-1:0]   st_set;
  logic [mrc_pkg::ST_W-1:0]   st_clr;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  logic                       irq_r;
  logic                       irq_nxt;
  logic                       busy_r;
  logic                       busy_nxt;

  // report sequencer
  always_comb
  begin
    state_nxt  = state_r;
    code_nxt   = code_r;
    valid_nxt  = 1'b0;
    dte_nxt    = dte_r;
    line_nxt   = line_r;
    prot_nxt   = prot_r;
    comp_nxt   = comp_r;
    ec_nxt     = ec_r;
    stream_nxt = stream_r;
    noans_hit  = 1'b0;
    unique case (state_r)
      S_IDLE:
      begin
        if (ev_connect)
        begin
          dte_nxt    = dte_rate;
          line_nxt   = line_rate;
          prot_nxt   = protocol;
          comp_nxt   = compression;
          ec_nxt     = ec_mode;
          stream_nxt = streaming_used;
          state_nxt  = ctrl_r[mrc_pkg::CTRL_NEG_ON] ? S_CARRIER : S_CONNECT;
        end
        // no answer only under quiet-answer modifier
        else if (ev_no_answer && quiet_answer_mod)
        begin
          code_nxt  = mrc_pkg::C_NO_ANSWER;
          valid_nxt = 1'b1;
          noans_hit = 1'b1;
        end
      end
      S_CARRIER:
      begin
        if (car_c != mrc_pkg::C_NONE)
        begin
          code_nxt  = car_c;
          valid_nxt = 1'b1;
        end
        state_nxt = S_PROTOCOL;
      end
      // protocol code is base plus variant
      S_PROTOCOL:
      begin
        code_nxt  = mrc_pkg::C_PROT_BASE + {5'h00, prot_r};
        valid_nxt = 1'b1;
        state_nxt = stream_r ? S_STREAM : S_COMPRESS;
      end
      S_STREAM:
      begin
        code_nxt  = mrc_pkg::C_STREAM;
        valid_nxt = 1'b1;
        state_nxt = S_COMPRESS;
      end
      // compression code is base plus scheme
      S_COMPRESS:
      begin
        code_nxt  = mrc_pkg::C_COMP_BASE + {6'h00, comp_r};
        valid_nxt = 1'b1;
        state_nxt = S_CONNECT;
      end
      // line speed stands in without error control
      S_CONNECT:
      begin
        code_nxt  = connect_code(ec_r ? dte_r : line_r, ctrl_r[mrc_pkg::CTRL_BASIC]);
        valid_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r  <= S_IDLE;
      code_r   <= mrc_pkg::C_NONE;
      valid_r  <= 1'b0;
      dte_r    <= mrc_pkg::R_300;
      line_r   <= mrc_pkg::R_300;
      prot_r   <= mrc_pkg::P_NONE;
      comp_r   <= mrc_pkg::CP_NONE;
      ec_r     <= 1'b0;
      stream_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      code_r   <= code_nxt;
      valid_r  <= valid_nxt;
      dte_r    <= dte_nxt;
      line_r   <= line_nxt;
      prot_r   <= prot_nxt;
      comp_r   <= comp_nxt;
      ec_r     <= ec_nxt;
      stream_r <= stream_nxt;
    end
  end

  // register port, sticky status and interrupt
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    en_nxt    = en_r;
    st_clr    = '0;
    rdata_nxt = 32'h0000_0000;
    st_set    = '0;
    st_set[mrc_pkg::ST_CODE]    = valid_nxt;
    st_set[mrc_pkg::ST_NOANS]   = noans_hit;
    st_set[mrc_pkg::ST_CONNECT] = (state_r == S_CONNECT);
    if (wr)
    begin
      unique case (addr[7:0])
        mrc_pkg::A_CTRL:    ctrl_nxt = wdata[mrc_pkg::CTRL_W-1:0];
        mrc_pkg::A_IRQ_EN:  en_nxt   = wdata[mrc_pkg::ST_W-1:0];
        mrc_pkg::A_IRQ_CLR: st_clr   = wdata[mrc_pkg::ST_W-1:0];
        default:            ctrl_nxt = ctrl_r;
      endcase
    end
    // set wins over a clear in the same cycle
    st_nxt = (st_r & ~st_clr) | st_set;
    if (rd)
    begin
      unique case (addr[7:0])
        mrc_pkg::A_CTRL:   rdata_nxt[mrc_pkg::CTRL_W-1:0] = ctrl_r;
        mrc_pkg::A_STATUS: rdata_nxt[mrc_pkg::ST_W-1:0]   = st_r;
        mrc_pkg::A_IRQ_EN: rdata_nxt[mrc_pkg::ST_W-1:0]   = en_r;
        mrc_pkg::A_LAST:
        begin
          rdata_nxt[7:0]               = code_r;
          rdata_nxt[mrc_pkg::LAST_BUSY] = (state_r != S_IDLE);
        end
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
    irq_nxt  = |(st_nxt & en_nxt);
    busy_nxt = (state_nxt != S_IDLE);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r  <= mrc_pkg::CTRL_RST;
      st_r    <= mrc_pkg::ST_RST;
      en_r    <= mrc_pkg::ST_RST;
      rdata_r <= 32'h0000_0000;
      irq_r   <= 1'b0;
      busy_r  <= 1'b0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      st_r    <= st_nxt;
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign rdata      = rdata_r;
  assign code       = code_r;
  assign code_valid = valid_r;
  assign busy       = busy_r;
  assign irq        = irq_r;

  // checks
  logic take_conn;
  logic neg_on;
  logic basic;
  assign take_conn = (state_r == S_IDLE) && ev_connect;
  assign neg_on    = ctrl_r[mrc_pkg::CTRL_NEG_ON];
  assign basic     = ctrl_r[mrc_pkg::CTRL_BASIC];

  sequence s_neg_start;
    take_conn && neg_on;
  endsequence

  sequence s_prot_to_comp;
    (state_r == S_PROTOCOL) ##1 (state_r == S_COMPRESS) ##1 (state_r == S_CONNECT);
  endsequence

  property p_no_answer;
    @(posedge clk) disable iff (reset)
      (state_r == S_IDLE) && !ev_connect && ev_no_answer
      |=> (code_valid == $past(quiet_answer_mod)) && (!$past(quiet_answer_mod) || code == mrc_pkg::C_NO_ANSWER);
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("no answer code wrong");

  property p_basic;
    @(posedge clk) disable iff (reset)
      (state_r == S_CONNECT) && basic && is_extended(ec_r ? dte_r : line_r)
      |=> code_valid && code == mrc_pkg::C_CONNECT;
  endproperty
  a_basic: assert property (p_basic) else $error("basic set not suppressing");

  property p_line_speed;
    @(posedge clk) disable iff (reset)
      (state_r == S_CONNECT) && !ec_r && !basic && line_r == mrc_pkg::R_9600 && dte_r != mrc_pkg::R_9600
      |=> code == mrc_pkg::C_CON_9600;
  endproperty
  a_line_speed: assert property (p_line_speed) else $error("connect not at line speed");

  property p_neg_off;
    @(posedge clk) disable iff (reset)
      take_conn && !neg_on |=> (state_r == S_CONNECT) && !code_valid ##1 code_valid && state_r == S_IDLE;
  endproperty
  a_neg_off: assert property (p_neg_off) else $error("progress message while disabled");

  property p_order;
    @(posedge clk) disable iff (reset)
      s_neg_start |=> (state_r == S_CARRIER) ##1 (state_r == S_PROTOCOL);
  endproperty
  a_order: assert property (p_order) else $error("negotiation order wrong");

  property p_no_stream;
    @(posedge clk) disable iff (reset)
      (state_r == S_PROTOCOL) && !stream_r |-> s_prot_to_comp;
  endproperty
  a_no_stream: assert property (p_no_stream) else $error("stream message not skipped");

  property p_carrier;
    @(posedge clk) disable iff (reset)
      (state_r == S_CARRIER) && line_r == mrc_pkg::R_1200 |=> code_valid && code == 8'h2E;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier code wrong");

  property p_comp;
    @(posedge clk) disable iff (reset)
      (state_r == S_COMPRESS) && comp_r == mrc_pkg::CP_NONE |=> code_valid && code == 8'h45;
  endproperty
  a_comp: assert property (p_comp) else $error("no compression code wrong");

  property p_prot;
    @(posedge clk) disable iff (reset)
      (state_r == S_PROTOCOL) && prot_r == mrc_pkg::P_X25_HDX |=> code_valid && code == 8'h4C;
  endproperty
  a_prot: assert property (p_prot) else $error("protocol code wrong");

  property p_one_code;
    @(posedge clk) disable iff (reset)
      take_conn && !neg_on |=> !code_valid ##1 code_valid ##1 !code_valid;
  endproperty
  a_one_code: assert property (p_one_code) else $error("more than one code per event");

endmodule : mrc_reporter

// *** hw/mrc_pkg.sv ***
// constants for the modem result code reporter
// assumes one 25 MHz clock and a word-aligned register port
package mrc_pkg;

  // rates: terminal side and line side share one coding
  typedef enum logic [3:0] {
    R_300, R_1200, R_1200_75, R_75_1200, R_2400, R_4800,
    R_7200, R_9600, R_12000, R_14400, R_19200, R_38400
  } mrc_rate_t;

  typedef enum logic [2:0] {
    P_NONE, P_LAPB, P_LAPB_HDX, P_LAPB_ASYNC, P_X25, P_X25_ASYNC, P_X25_HDX
  } mrc_prot_t;

  typedef enum logic [1:0] {
    CP_CLASS5, CP_V42BIS, CP_ADAPTIVE, CP_NONE
  } mrc_comp_t;

  // register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ_EN  = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0C;
  localparam logic [7:0] A_LAST    = 8'h10;

  // control fields
  localparam int         CTRL_BASIC  = 0;
  localparam int         CTRL_NEG_ON = 1;
  localparam int         CTRL_W      = 2;
  localparam logic [1:0] CTRL_RST    = 2'h0;

  // status and interrupt fields
  localparam int         ST_CODE    = 0;
  localparam int         ST_NOANS   = 1;
  localparam int         ST_CONNECT = 2;
  localparam int         ST_W       = 3;
  localparam logic [2:0] ST_RST     = 3'h0;

  // last code register: code low byte, busy above it
  localparam int LAST_BUSY = 8;

  // result codes
  localparam logic [7:0] C_NONE       = 8'h00;
  localparam logic [7:0] C_CONNECT    = 8'h01;
  localparam logic [7:0] C_CON_1200   = 8'h05;
  localparam logic [7:0] C_NO_ANSWER  = 8'h08;
  localparam logic [7:0] C_CON_2400   = 8'h0A;
  localparam logic [7:0] C_CON_4800   = 8'h0B;
  localparam logic [7:0] C_CON_9600   = 8'h0C;
  localparam logic [7:0] C_CON_14400  = 8'h0D;
  localparam logic [7:0] C_CON_19200  = 8'h0E;
  localparam logic [7:0] C_CON_1200_75 = 8'h16;
  localparam logic [7:0] C_CON_75_1200 = 8'h17;
  localparam logic [7:0] C_CON_7200   = 8'h18;
  localparam logic [7:0] C_CON_12000  = 8'h19;
  localparam logic [7:0] C_CON_38400  = 8'h1C;
  localparam logic [7:0] C_CAR_300    = 8'h28;
  localparam logic [7:0] C_CAR_1200_75 = 8'h2C;
  localparam logic [7:0] C_CAR_75_1200 = 8'h2D;
  localparam logic [7:0] C_CAR_1200   = 8'h2E;
  localparam logic [7:0] C_CAR_2400   = 8'h2F;
  localparam logic [7:0] C_CAR_4800   = 8'h30;
  localparam logic [7:0] C_CAR_7200   = 8'h31;
  localparam logic [7:0] C_CAR_9600   = 8'h32;
  localparam logic [7:0] C_CAR_12000  = 8'h33;
  localparam logic [7:0] C_CAR_14400  = 8'h34;
  localparam logic [7:0] C_STREAM     = 8'h3C;
  localparam logic [7:0] C_COMP_BASE  = 8'h42;
  localparam logic [7:0] C_PROT_BASE  = 8'h46;

endpackage : mrc_pkg

// *** test/mrc_dte_model.sv ***
// terminal side model: queues every result code the reporter emits
// assumes code is settled in each cycle where code_valid is high
module mrc_dte_model (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] code,
  input wire logic       code_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got [$];

  always @(posedge clk)
  begin
    if (reset === 1'b0 && code_valid === 1'b1)
      got.push_back(code);
  end
endmodule : mrc_dte_model

// *** test/mrc_reporter_tb.sv ***
// self-checking bench for the result code reporter
// assumes the terminal model queues each emitted code in order
module mrc_reporter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk = 1'b0;
  logic                reset;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic                wr;
  logic                rd;
  logic [31:0]         rdata;
  logic                ev_no_answer;
  logic                quiet_answer_mod;
  logic                ev_connect;
  logic                ec_mode;
  mrc_pkg::mrc_rate_t  dte_rate;
  mrc_pkg::mrc_rate_t  line_rate;
  logic                streaming_used;
  mrc_pkg::mrc_prot_t  protocol;
  mrc_pkg::mrc_comp_t  compression;
  logic [7:0]          code;
  logic                code_valid;
  logic                busy;
  logic                irq;
  int                  miscompares = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  logic [7:0]          exp_q [$];

  // connect and carrier codes by rate index
  localparam logic [7:0] CON_TAB [12] = '{8'h01, 8'h05, 8'h16, 8'h17, 8'h0A, 8'h0B,
                                          8'h18, 8'h0C, 8'h19, 8'h0D, 8'h0E, 8'h1C};
  localparam logic [7:0] CAR_TAB [12] = '{8'h28, 8'h2E, 8'h2C, 8'h2D, 8'h2F, 8'h30,
                                          8'h31, 8'h32, 8'h33, 8'h34, 8'h00, 8'h00};

  always #20 clk = ~clk;

  mrc_reporter i_dut (
    .clk              (clk),
    .reset            (reset),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .rdata            (rdata),
    .ev_no_answer     (ev_no_answer),
    .quiet_answer_mod (quiet_answer_mod),
    .ev_connect       (ev_connect),
    .ec_mode          (ec_mode),
    .dte_rate         (dte_rate),
    .line_rate        (line_rate),
    .streaming_used   (streaming_used),
    .protocol         (protocol),
    .compression      (compression),
    .code             (code),
    .code_valid       (code_valid),
    .busy             (busy),
    .irq              (irq)
  );

  mrc_dte_model i_dte (
    .clk        (clk),
    .reset      (reset),
    .code       (code),
    .code_valid (code_valid)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : reg_rd

  // pulse an event for len cycles, then wait for the sequencer to idle
  task automatic fire(input logic con, input logic na, input int len = 1);
    int n = 0;
    @(posedge clk);
    ev_connect   <= con;
    ev_no_answer <= na;
    repeat (len) @(posedge clk);
    ev_connect   <= 1'b0;
    ev_no_answer <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
    repeat (2) @(posedge clk);
  endtask : fire

  task automatic cmp_q();
    chk(32'(i_dte.got.size()), 32'(exp_q.size()));
    foreach (exp_q[k])
      if (k < i_dte.got.size()) chk({24'h0, i_dte.got[k]}, {24'h0, exp_q[k]});
    i_dte.got.delete();
    exp_q.delete();
  endtask : cmp_q

  task automatic con(input int lr, input int dr, input logic ec, input logic bas, input logic neg,
                     input logic strm, input int p, input int c, input int len = 1);
    int cr;
    cr = ec ? dr : lr;
    line_rate      <= mrc_pkg::mrc_rate_t'(lr[3:0]);
    dte_rate       <= mrc_pkg::mrc_rate_t'(dr[3:0]);
    ec_mode        <= ec;
    streaming_used <= strm;
    protocol       <= mrc_pkg::mrc_prot_t'(p[2:0]);
    compression    <= mrc_pkg::mrc_comp_t'(c[1:0]);
    if (neg)
    begin
      if (CAR_TAB[lr] !== 8'h00)
        exp_q.push_back(CAR_TAB[lr]);
      exp_q.push_back(8'h46 + 8'(p));
      if (strm)
        exp_q.push_back(mrc_pkg::C_STREAM);
      exp_q.push_back(8'h42 + 8'(c));
    end
    exp_q.push_back((bas && cr >= 4) ? 8'h01 : CON_TAB[cr]);
    fire(1'b1, 1'b0, len);
    cmp_q();
  endtask : con

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      $display("MISMATCH at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial
  begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    ev_no_answer = 1'b0;
    quiet_answer_mod = 1'b0;
    ev_connect = 1'b0;
    ec_mode = 1'b0;
    dte_rate = mrc_pkg::R_300;
    line_rate = mrc_pkg::R_300;
    streaming_used = 1'b0;
    protocol = mrc_pkg::P_NONE;
    compression = mrc_pkg::CP_NONE;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    reg_rd(mrc_pkg::A_CTRL, 32'h0);
    reg_rd(mrc_pkg::A_STATUS, 32'h0);
    reg_rd(mrc_pkg::A_IRQ_EN, 32'h0);
    reg_rd(mrc_pkg::A_LAST, 32'h0);
    reg_rd(8'h14, 32'h0);
    fire(1'b0, 1'b1);
    cmp_q();
    quiet_answer_mod <= 1'b1;
    exp_q.push_back(8'h08);
    fire(1'b0, 1'b1);
    cmp_q();
    reg_rd(mrc_pkg::A_LAST, 32'h08);
    for (int b = 0; b < 2; b++)
    begin
      reg_wr(mrc_pkg::A_CTRL, 32'(b));
      for (int r = 0; r < 12; r++)
        con(r, (r + 3) % 12, 1'b0, b[0], 1'b0, 1'b0, 0, 0);
    end
    reg_wr(mrc_pkg::A_CTRL, 32'h0);
    for (int r = 0; r < 12; r++)
      con((r + 5) % 12, r, 1'b1, 1'b0, 1'b0, 1'b0, 0, 0);
    reg_wr(mrc_pkg::A_CTRL, 32'h2);
    reg_rd(mrc_pkg::A_CTRL, 32'h2);
    for (int r = 0; r < 12; r++)
      con(r, r, 1'b0, 1'b0, 1'b1, r[0], r % 7, r % 4);
    con(8, 8, 1'b0, 1'b0, 1'b1, 1'b1, 6, 1, 2);
    // status, enable and clear
    reg_rd(mrc_pkg::A_STATUS, 32'h7);
    reg_wr(mrc_pkg::A_IRQ_EN, 32'h4);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    reg_wr(mrc_pkg::A_IRQ_CLR, 32'h7);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    reg_wr(mrc_pkg::A_STATUS, 32'h7);
    reg_rd(mrc_pkg::A_STATUS, 32'h0);
    reg_rd(mrc_pkg::A_IRQ_CLR, 32'h0);
    exp_q.push_back(8'h08);
    fire(1'b0, 1'b1);
    cmp_q();
    chk({31'h0, irq}, 32'h0);
    reg_rd(mrc_pkg::A_STATUS, 32'h3);
    reg_wr(mrc_pkg::A_IRQ_EN, 32'h2);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    reg_wr(mrc_pkg::A_IRQ_CLR, 32'h2);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    reg_rd(mrc_pkg::A_IRQ_EN, 32'h2);
    end_of_test();
  end
endmodule : mrc_reporter_tb
